// ### src/amc_clk_div.sv
// Purpose: Conversion clock tick generator, system clock divided by 8, 4, 2 or 1
// Assumes: run_i low restarts the prescaler
// Notes: tick_o is a one-cycle pulse per conversion clock
`timescale 1ns/1ns
module amc_clk_div (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] div_sel_i,
  output logic tick_o
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] last;

  always_comb begin
    unique case (div_sel_i)
      2'b00: last = 3'h7;
      2'b01: last = 3'h3;
      2'b10: last = 3'h1;
      2'b11: last = 3'h0;
    endcase
    cnt_d = (!run_i || cnt_q >= last) ? 3'h0 : cnt_q + 3'h1;
    tick_o = run_i && (cnt_q >= last);
  end

  // Prescaler count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // amc_clk_div

// ### src/amc_mode_ctrl.sv
// Purpose: Mode register, start/stop and conversion timing of the converter
// Assumes: register port strobes one cycle, read data valid the next cycle
// Notes: interrupt status bit 0 is conversion done, write one to clear
// Contract
// - Converter runs only while run bit is one, else stopped or standby
// - Run bit clears on a written zero or at conversion end
// - Run bit sets only by writing one while comparator enable is one
// - Writing run one with both bits zero leaves run zero
// - Comparator is enabled exactly while the comparator enable bit is one
// - Divider codes give clk/8,4,2,1; 10-bit length 23 or 17 clocks
// - Resolution bit zero selects 10-bit, one selects 8-bit
// - 8-bit conversions last 21 or 15 conversion clocks
// - Every conversion completion while the gate bit is one sets the conversion done interrupt status bit
// - Gate bit zero holds converter in reset, ignoring register writes except to the gate register
`timescale 1ns/1ns
module amc_mode_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic cmp_enable_o,
  output logic sample_o,
  output logic convert_o,
  output logic resolution_8bit_o,
  output logic conversion_done_o,
  output logic first_result_unsettled_o,
  output logic conversion_done_irq_o
);
  amc_pkg::amc_req_t req;
  amc_pkg::amc_mode_t mode_q, mode_d;
  amc_pkg::amc_state_t state_q, state_d;
  logic gate_q, gate_d;
  logic res_q, res_d;
  logic stat_q, stat_d;
  logic mask_q, mask_d;
  logic unsettled_q, unsettled_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic tick;
  logic settled;
  logic done;
  logic [4:0] samp_len;
  logic [4:0] conv_len;
  logic [7:0] mode_rd;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  amc_clk_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_q != amc_pkg::ST_IDLE),
    .div_sel_i(mode_q.div_sel),
    .tick_o(tick)
  );

  amc_settle u_settle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmp_en_i(mode_q.cmp_en),
    .settled_o(settled)
  );

  always_comb begin
    samp_len = mode_q.short_sample ? amc_pkg::SAMP_SHORT : amc_pkg::SAMP_LONG;
    if (res_q) begin
      conv_len = mode_q.short_sample ? amc_pkg::LEN_8_SHORT : amc_pkg::LEN_8_LONG;
    end else begin
      conv_len = mode_q.short_sample ? amc_pkg::LEN_10_SHORT : amc_pkg::LEN_10_LONG;
    end
  end

  // final conversion clock ends the conversion
  // A stop written in the last cycle of a conversion comes too late; the conversion still completes
  assign done = (state_q == amc_pkg::ST_CONVERT) && mode_q.run && tick &&
                (cnt_q == conv_len - 5'h01);

  // sequencer: sampling clocks, then conversion clocks
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      amc_pkg::ST_IDLE: begin
        cnt_d = 5'h00;
        if (mode_q.run) begin
          state_d = amc_pkg::ST_SAMPLE;
        end
      end
      amc_pkg::ST_SAMPLE: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == samp_len - 5'h01) begin
            state_d = amc_pkg::ST_CONVERT;
          end
        end
      end
      amc_pkg::ST_CONVERT: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h01;
        end
        if (done) begin
          state_d = amc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = amc_pkg::ST_IDLE;
      end
    endcase
    // stopping the run bit aborts the conversion
    if (!mode_q.run || !gate_q) begin
      state_d = amc_pkg::ST_IDLE;
      cnt_d = 5'h00;
    end
  end

  // Register writes and run bit control
  always_comb begin
    mode_d = mode_q;
    gate_d = gate_q;
    res_d = res_q;
    mask_d = mask_q;
    stat_d = stat_q;
    unsettled_d = unsettled_q;
    if (done) begin
      mode_d.run = 1'b0;
    end
    if (req.wr && req.addr == amc_pkg::GATE_OFS) begin
      gate_d = req.wdata[amc_pkg::GATE_BIT];
    end
    if (req.wr && gate_q) begin
      if (req.addr == amc_pkg::MODE_OFS) begin
        mode_d.cmp_en = req.wdata[amc_pkg::CMP_BIT];
        mode_d.div_sel = {req.wdata[amc_pkg::DIV_HI_BIT], req.wdata[amc_pkg::DIV_LO_BIT]};
        mode_d.short_sample = req.wdata[amc_pkg::SHORT_BIT];
        // set only when comparator already enabled
        if (req.wdata[amc_pkg::RUN_BIT]) begin
          if (mode_q.cmp_en && req.wdata[amc_pkg::CMP_BIT] && !mode_q.run) begin
            mode_d.run = 1'b1;
            unsettled_d = !settled;
          end
        end else begin
          mode_d.run = 1'b0;
        end
        // disabling the comparator stops the run
        if (!req.wdata[amc_pkg::CMP_BIT]) begin
          mode_d.run = 1'b0;
        end
      end
      if (req.addr == amc_pkg::RES_OFS) begin
        res_d = req.wdata[amc_pkg::RES_BIT];
      end
      if (req.addr == amc_pkg::IRQ_MASK_OFS) begin
        mask_d = req.wdata[0];
      end
      if (req.addr == amc_pkg::IRQ_STAT_OFS && req.wdata[0]) begin
        stat_d = 1'b0;
      end
    end
    // set wins over a clearing write
    if (done) begin
      stat_d = 1'b1;
    end
    if (!gate_q) begin
      mode_d = '0;
      res_d = 1'b0;
      mask_d = 1'b0;
      stat_d = 1'b0;
      unsettled_d = 1'b0;
    end
  end

  // Read mux
  always_comb begin
    mode_rd = amc_pkg::MODE_RST;
    mode_rd[amc_pkg::RUN_BIT] = mode_q.run;
    mode_rd[amc_pkg::DIV_HI_BIT] = mode_q.div_sel[1];
    mode_rd[amc_pkg::DIV_LO_BIT] = mode_q.div_sel[0];
    mode_rd[amc_pkg::SHORT_BIT] = mode_q.short_sample;
    mode_rd[amc_pkg::CMP_BIT] = mode_q.cmp_en;
    rdata_d = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        amc_pkg::MODE_OFS: rdata_d = mode_rd;
        amc_pkg::RES_OFS: rdata_d = {7'h00, res_q};
        amc_pkg::GATE_OFS: rdata_d = {2'h0, gate_q, 5'h00};
        amc_pkg::IRQ_STAT_OFS: rdata_d = {7'h00, stat_q};
        amc_pkg::IRQ_MASK_OFS: rdata_d = {7'h00, mask_q};
        amc_pkg::STATUS_OFS: rdata_d = {4'h0, unsettled_q, settled, state_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= '0;
      state_q <= amc_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      gate_q <= 1'b0;
      res_q <= 1'b0;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      unsettled_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      gate_q <= gate_d;
      res_q <= res_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      unsettled_q <= unsettled_d;
      rdata_q <= rdata_d;
    end
  end

  assign cmp_enable_o = mode_q.cmp_en;
  assign sample_o = (state_q == amc_pkg::ST_SAMPLE);
  assign convert_o = (state_q == amc_pkg::ST_CONVERT);
  assign resolution_8bit_o = res_q;
  assign conversion_done_o = done;
  assign first_result_unsettled_o = unsettled_q;
  assign conversion_done_irq_o = stat_q && mask_q;
  assign rdata_o = rdata_q;

  // cycles spent sampling and converting, watched by the length check
  logic [7:0] run_len_q, run_len_d;
  always_comb begin
    run_len_d = (state_q == amc_pkg::ST_IDLE) ? 8'h00 : run_len_q + 8'h01;
  end

  // Length counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_len_q <= 8'h00;
    end else begin
      run_len_q <= run_len_d;
    end
  end

  sequence s_start_write;
    wr_i && addr_i == amc_pkg::MODE_OFS && wdata_i[amc_pkg::RUN_BIT] && gate_q;
  endsequence

  sequence s_mode_write;
    wr_i && addr_i == amc_pkg::MODE_OFS && gate_q;
  endsequence

  sequence s_res_write;
    wr_i && addr_i == amc_pkg::RES_OFS && gate_q;
  endsequence

  chk_run_needs_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q.run |-> mode_q.cmp_en) else $error("run set without comparator");
  chk_run_set_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start_write ##0 (mode_q.cmp_en && wdata_i[0] && !mode_q.run) |=> mode_q.run)
    else $error("run not set");
  chk_run_set_block: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start_write ##0 (!mode_q.cmp_en && !mode_q.run) |=> !mode_q.run)
    else $error("run set while stopped");
  chk_done_clears_run: assert property (@(posedge clk_i) disable iff (rst_i)
    done |=> !mode_q.run) else $error("run not cleared at end");
  chk_idle_when_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_q.run |=> state_q == amc_pkg::ST_IDLE) else $error("active while stopped");
  chk_done_irq_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    done && gate_q |=> stat_q) else $error("done not flagged");
  chk_gate_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    !gate_q |=> mode_q == '0 && !res_q) else $error("gate low not holding reset");
  chk_fast_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mode_q.run) && mode_q.div_sel == 2'b11 && !res_q && !mode_q.short_sample
    |-> ##24 !mode_q.run) else $error("10-bit length wrong");
  chk_fast_length8: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mode_q.run) && mode_q.div_sel == 2'b11 && res_q && mode_q.short_sample
    |-> ##15 mode_q.run ##1 !mode_q.run) else $error("8-bit length wrong");
  chk_cmp_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_mode_write |=> cmp_enable_o == $past(wdata_i[amc_pkg::CMP_BIT]))
    else $error("comparator enable not following write");
  chk_res_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_res_write |=> resolution_8bit_o == $past(wdata_i[amc_pkg::RES_BIT]))
    else $error("resolution not following write");
  chk_stop_clears_run: assert property (@(posedge clk_i) disable iff (rst_i)
    s_mode_write ##0 !wdata_i[amc_pkg::RUN_BIT] |=> !mode_q.run)
    else $error("written zero did not stop");
  chk_sample_first: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mode_q.run) |=> sample_o) else $error("sampling not first");
  chk_unsettled_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mode_q.run) |-> first_result_unsettled_o == !$past(settled))
    else $error("unsettled flag wrong");
  chk_run_length: assert property (@(posedge clk_i) disable iff (rst_i)
    done |-> run_len_q == ({3'h0, conv_len} << (2'h3 - mode_q.div_sel)) - 8'h01)
    else $error("conversion length wrong");
endmodule // amc_mode_ctrl

// ### src/amc_pkg.sv
// Purpose: Shared constants and types for the converter mode/start control block
// Assumes: 8-bit register port, 125 MHz system clock
// Notes: Register offsets below the mode register are locally assigned
package amc_pkg;

  // Register offsets
  localparam logic [19:0] MODE_OFS = 20'hFFF30;
  localparam logic [19:0] RES_OFS = 20'hF0010;
  localparam logic [19:0] GATE_OFS = 20'hF00F0;
  localparam logic [19:0] IRQ_STAT_OFS = 20'hF0100;
  localparam logic [19:0] IRQ_MASK_OFS = 20'hF0101;
  localparam logic [19:0] STATUS_OFS = 20'hF0102;

  // Mode register field positions
  localparam int RUN_BIT = 7;
  localparam int DIV_HI_BIT = 4;
  localparam int DIV_LO_BIT = 3;
  localparam int SHORT_BIT = 1;
  localparam int CMP_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'h9B;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Gate register and resolution register field positions
  localparam int GATE_BIT = 5;
  localparam int RES_BIT = 0;

  // Conversion lengths in conversion clocks
  localparam logic [4:0] LEN_10_LONG = 5'h17;
  localparam logic [4:0] LEN_10_SHORT = 5'h11;
  localparam logic [4:0] LEN_8_LONG = 5'h15;
  localparam logic [4:0] LEN_8_SHORT = 5'h0F;
  localparam logic [4:0] SAMP_LONG = 5'h09;
  localparam logic [4:0] SAMP_SHORT = 5'h03;

  // Comparator settle time
  localparam int SETTLE_NS = 100;
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  // Mode register contents
  typedef struct packed {
    logic run;
    logic [1:0] div_sel;
    logic short_sample;
    logic cmp_en;
  } amc_mode_t;

  // Register port request
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } amc_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } amc_state_t;

endpackage

// ### src/amc_settle.sv
// Purpose: Tracks comparator settle time after enable
// Assumes: cmp_en_i is the comparator enable bit
// Notes: settled_o high once the settle time has passed
`timescale 1ns/1ns
module amc_settle #(
  parameter int CYC = amc_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmp_en_i,
  output logic settled_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Count up while enabled, saturate at the settle count
  always_comb begin
    if (!cmp_en_i) begin
      cnt_d = 8'h00;
    end else if (cnt_q < 8'(CYC)) begin
      cnt_d = cnt_q + 8'h01;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign settled_o = (cnt_q >= 8'(CYC));
endmodule // amc_settle

// ### verification/amc_tb.sv
// Purpose: Self-checking bench for the converter mode and start control block
// Assumes: register port with one-cycle strobes, read data one cycle after the read strobe
// Notes: drives the block's ports directly; random mode order from a fixed seed
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  logic clk_i, rst_i, wr_i, rd_i;
  logic [19:0] addr_i;
  logic [7:0] wdata_i, rdata_o, rv;
  logic cmp_o, smp_o, cnv_o, r8_o, done_o, uns_o, irq_o;
  int fails, n_tests, cyc, ns, nc, nd, r;

  amc_mode_ctrl u_amc_mode_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cmp_enable_o(cmp_o), .sample_o(smp_o),
    .convert_o(cnv_o), .resolution_8bit_o(r8_o), .conversion_done_o(done_o),
    .first_result_unsettled_o(uns_o), .conversion_done_irq_o(irq_o)
  );

  // Clock at 125 MHz
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end

  // Counts and verdict, then ends the run
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One write cycle on the register port
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // One read cycle; the data are taken in the single cycle they stand
  task automatic rd(input logic [19:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask

  // Conversion length in conversion clocks
  function automatic int len_of(input bit r8, input bit sh);
    return r8 ? (sh ? 15 : 21) : (sh ? 17 : 23);
  endfunction

  // Runs one conversion with mode bits m and checks phase lengths and completion
  task automatic conv(input logic [7:0] m, input bit r8, input bit st);
    int dv;
    int ls;
    dv = 8 >> m[4:3];
    ls = m[1] ? 3 : 9;
    wr(amc_pkg::MODE_OFS, 8'h00);
    wr(amc_pkg::RES_OFS, {7'h00, r8});
    `CHK(r8_o, r8)
    // select bits while stopped, comparator first, unused bits zero
    wr(amc_pkg::MODE_OFS, m | 8'h01);
    `CHK(cmp_o, 1'b1)
    if (st)
      repeat (amc_pkg::SETTLE_CYC) @(posedge clk_i);
    // start alone, after settling unless st is clear
    wr(amc_pkg::MODE_OFS, m | 8'h81);
    ns = 0;
    nc = 0;
    nd = 0;
    for (int k = 0; k < 400 && nd == 0; k++) begin
      @(posedge clk_i);
      #1;
      ns += (smp_o === 1'b1);
      nc += (cnv_o === 1'b1);
      nd += (done_o === 1'b1);
    end
    `CHK(uns_o, !st)
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(ns, ls * dv)
    `CHK(nc, (len_of(r8, m[1]) - ls) * dv)
    `CHK(nd, 1)
    `CHK({smp_o, cnv_o, done_o}, 3'b000)
    rd(amc_pkg::MODE_OFS);
    `CHK(rv, m | 8'h01)
  endtask

  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 20'h00000;
    wdata_i = 8'h00;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(32'h83354dcb));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Register reset value and gate-off write lock
    rd(amc_pkg::MODE_OFS);
    `CHK(rv, 8'h00)
    wr(amc_pkg::MODE_OFS, 8'h19);
    rd(amc_pkg::MODE_OFS);
    `CHK(rv, 8'h00)
    `CHK(cmp_o, 1'b0)
    wr(amc_pkg::GATE_OFS, 8'h20);
    // Start refused while comparator is off
    wr(amc_pkg::MODE_OFS, 8'h80);
    rd(amc_pkg::MODE_OFS);
    `CHK(rv, 8'h00)
    wr(amc_pkg::MODE_OFS, 8'h81);
    rd(amc_pkg::MODE_OFS);
    `CHK(rv, 8'h01)
    `CHK(smp_o, 1'b0)
    // Every divider, sampling and resolution choice, in random order
    r = $urandom_range(15);
    for (int i = 0; i < 16; i++) begin
      logic [3:0] c;
      c = 4'(i ^ r);
      // short sampling assumes the upper supply range
      conv({3'b000, c[1:0], 1'b0, c[2], 1'b0}, c[3], i != 3);
    end
    // Unmapped addresses read zero
    repeat (4) begin
      rd(20'h00100 + 20'($urandom_range(255)));
      `CHK(rv, 8'h00)
    end
    // Interrupt masked, unmasked, then cleared
    `CHK(irq_o, 1'b0)
    rd(amc_pkg::IRQ_STAT_OFS);
    `CHK(rv[0], 1'b1)
    wr(amc_pkg::IRQ_MASK_OFS, 8'h01);
    `CHK(irq_o, 1'b1)
    wr(amc_pkg::IRQ_STAT_OFS, 8'h01);
    `CHK(irq_o, 1'b0)
    // Stop written during sampling aborts without completion
    wr(amc_pkg::MODE_OFS, 8'h19);
    repeat (amc_pkg::SETTLE_CYC) @(posedge clk_i);
    wr(amc_pkg::MODE_OFS, 8'h99);
    repeat (5) @(posedge clk_i);
    wr(amc_pkg::MODE_OFS, 8'h19);
    nd = 0;
    repeat (60) begin
      @(posedge clk_i);
      #1;
      nd += (done_o === 1'b1);
    end
    `CHK(nd, 0)
    `CHK({smp_o, cnv_o, irq_o}, 3'b000)
    // Gate off clears the mode and resolution registers
    wr(amc_pkg::RES_OFS, 8'h01);
    wr(amc_pkg::GATE_OFS, 8'h00);
    rd(amc_pkg::MODE_OFS);
    `CHK(rv, 8'h00)
    `CHK(cmp_o, 1'b0)
    rd(amc_pkg::RES_OFS);
    `CHK(rv, 8'h00)
    `CHK(r8_o, 1'b0)
    results();
  end
endmodule // tb
